// file: hdl/dac_ctrl_pkg.sv
/*
 Package for the converter control block: register offsets, field positions,
 reset values, power states and timing counts.
 Assumes a 10 MHz system clock and a plain register port with byte addresses.
*/
package dac_ctrl_pkg;

   // ==========================================================
   // Address map
   localparam logic [15:0] INSTANCE0_BASE = 16'h8000;
   localparam logic [15:0] INSTANCE1_BASE = 16'h8040;
   localparam logic [5:0] OFF_ACTIVATE = 6'h00;
   localparam logic [5:0] OFF_CONFIG = 6'h04;
   localparam logic [5:0] OFF_CONTROL = 6'h08;
   localparam logic [5:0] OFF_CODE = 6'h0c;
   localparam logic [5:0] OFF_RESERVED_FIRST = 6'h10;
   localparam logic [5:0] OFF_RESERVED_LAST = 6'h30;

   // ==========================================================
   // Field positions
   localparam int ACTIVATE_BIT = 0;
   localparam int CFG_INTERNAL_BIT = 0;
   localparam int CFG_PIN_BIT = 1;
   localparam int CFG_SLEEP_BIT = 2;
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_SOFT_RESET_BIT = 1;
   localparam int CODE_WIDTH = 12;

   // ==========================================================
   // Reset values
   localparam logic ACTIVATE_RESET = 1'b0;
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic CONTROL_RESET = 1'b0;
   localparam logic [11:0] CODE_RESET = 12'h000;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SOFT_RESET_WAIT_NS = 150;
   localparam int SOFT_RESET_WAIT_CYCLES =
      (SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES = 1;

   typedef enum logic [4:0] {
      ST_DEACTIVATED = 5'b00001,
      ST_SLEEPING = 5'b00010,
      ST_OFF = 5'b00100,
      ST_ON = 5'b01000,
      ST_CONVERTING = 5'b10000
   } power_state_type;

endpackage

// file: hdl/dac_analog_if.sv
/*
 Interface carrying the converter drive between the control core and the
 output stage. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface dac_analog_if;
   logic analog_on;
   logic pin_enable;
   logic internal_enable;
   logic [11:0] code;
   logic clock_gate;
   logic [11:0] code_out;
   logic pin_drive;
   logic internal_drive;
   logic pin_tristate;
   modport core (output analog_on, pin_enable, internal_enable, code, clock_gate,
      input code_out, pin_drive, internal_drive, pin_tristate);
   modport stage (input analog_on, pin_enable, internal_enable, code, clock_gate,
      output code_out, pin_drive, internal_drive, pin_tristate);
endinterface

// file: hdl/dac_output_stage.sv
/*
 Output stage: holds the code presented to the ladder and steers the pin and
 internal buffers. Assumes the core gates it with clock_gate.
*/
`timescale 1ns/1ps
module dac_output_stage
   import dac_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic soft_reset,
   input wire logic clk_en,
   // Core side
   dac_analog_if.stage port
);

   logic [11:0] code_q;
   logic pin_q;
   logic int_q;

   // ==========================================================
   // Sample and hold, whole code at once so the ladder never sees a torn value
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         code_q <= CODE_RESET;
      end else if (clk_en) begin
         if (soft_reset) begin
            code_q <= CODE_RESET;
         end else if (port.clock_gate && port.analog_on) begin
            code_q <= port.code;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_q <= 1'b0;
         int_q <= 1'b0;
      end else if (clk_en) begin
         if (soft_reset) begin
            pin_q <= 1'b0;
            int_q <= 1'b0;
         end else begin
            pin_q <= port.analog_on && port.pin_enable;
            int_q <= port.analog_on && port.internal_enable;
         end
      end
   end

   assign port.code_out = code_q;
   assign port.pin_drive = pin_q;
   assign port.internal_drive = int_q;
   assign port.pin_tristate = !pin_q;

endmodule

// file: hdl/dac_register_control.sv
/*
 Register bank and power sequencing for one converter instance.
 Assumes a plain register port on the system clock, with read data one cycle
 after the read strobe, and a sleep-enable input from another clock domain.
*/
`timescale 1ns/1ps
module dac_register_control
   import dac_ctrl_pkg::*;
#(
   parameter logic [15:0] BASE_ADDRESS = INSTANCE0_BASE
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // Register port
   input wire logic [15:0] addr,
   input wire logic [31:0] wdata,
   input wire logic write_en,
   input wire logic read_en,
   output logic [31:0] rdata,
   // Chip sleep request, asynchronous
   input wire logic sleep_enable,
   // Analog side
   output logic [11:0] code_out,
   output logic pin_drive,
   output logic internal_drive,
   output logic pin_tristate,
   output logic analog_on,
   output logic clock_gate,
   output logic [4:0] power_state
);

   dac_analog_if aif();

   logic activate_q;
   logic [2:0] config_q;
   logic on_q;
   logic [11:0] code_q;
   logic soft_reset_q;
   logic sleep_meta_q;
   logic sleep_sync_q;
   logic [31:0] rdata_q;
   logic settle_q;
   logic on_prev_q;
   logic [11:0] code_prev_q;
   power_state_type state_q;
   power_state_type state_d;
   logic hit;
   logic [5:0] offset;
   logic sel_activate;
   logic sel_config;
   logic sel_control;
   logic sel_code;
   logic sleeping;

   // ==========================================================
   // Address decode
   assign hit = (addr[15:6] == BASE_ADDRESS[15:6]);
   assign offset = addr[5:0];

   always_comb begin
      sel_activate = 1'b0;
      sel_config = 1'b0;
      sel_control = 1'b0;
      sel_code = 1'b0;
      if (!hit) begin
         sel_activate = 1'b0;
      end else if (offset == OFF_ACTIVATE) begin
         sel_activate = 1'b1;
      end else if (offset == OFF_CONFIG) begin
         sel_config = 1'b1;
      end else if (offset == OFF_CONTROL) begin
         sel_control = 1'b1;
      end else if (offset == OFF_CODE) begin
         sel_code = 1'b1;
      end
   end

   // ==========================================================
   // Sleep synchroniser
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sleep_meta_q <= 1'b0;
         sleep_sync_q <= 1'b0;
      end else if (clk_en) begin
         sleep_meta_q <= sleep_enable;
         sleep_sync_q <= sleep_meta_q;
      end
   end

   assign sleeping = config_q[CFG_SLEEP_BIT] && sleep_sync_q;

   // ==========================================================
   // Activate: of the two resets only the system reset clears it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         activate_q <= ACTIVATE_RESET;
      end else if (clk_en && write_en && sel_activate) begin
         activate_q <= wdata[ACTIVATE_BIT];
      end
   end

   // Soft reset pulse lasts one cycle and clears itself
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         soft_reset_q <= 1'b0;
      end else if (clk_en) begin
         soft_reset_q <= write_en && sel_control && wdata[CTRL_SOFT_RESET_BIT];
      end
   end

   // ==========================================================
   // Configuration, locked while the converter is on
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         config_q <= CONFIG_RESET;
      end else if (clk_en) begin
         if (soft_reset_q) begin
            config_q <= CONFIG_RESET;
         end else if (write_en && sel_config && !on_q) begin
            config_q <= wdata[2:0];
         end
      end
   end

   // On bit: refused while deactivated; dropping activate also drops it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         on_q <= CONTROL_RESET;
      end else if (clk_en) begin
         if (soft_reset_q || !activate_q) begin
            on_q <= CONTROL_RESET;
         end else if (write_en && sel_control && !wdata[CTRL_SOFT_RESET_BIT]) begin
            on_q <= wdata[CTRL_ON_BIT];
         end
      end
   end

   // Code is one register so a single write replaces all twelve bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         code_q <= CODE_RESET;
      end else if (clk_en) begin
         if (soft_reset_q) begin
            code_q <= CODE_RESET;
         end else if (write_en && sel_code) begin
            code_q <= wdata[CODE_WIDTH-1:0];
         end
      end
   end

   // ==========================================================
   // Read port; unmapped and reserved offsets read zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (!read_en) begin
            rdata_q <= 32'h0000_0000;
         end else if (sel_activate) begin
            rdata_q <= {31'h0, activate_q};
         end else if (sel_config) begin
            rdata_q <= {29'h0, config_q};
         end else if (sel_control) begin
            rdata_q <= {31'h0, on_q};
         end else if (sel_code) begin
            rdata_q <= {20'h0_0000, code_q};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign rdata = rdata_q;

   // ==========================================================
   // Power state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         on_prev_q <= 1'b0;
         code_prev_q <= CODE_RESET;
         settle_q <= 1'b0;
      end else if (clk_en) begin
         on_prev_q <= on_q;
         code_prev_q <= code_q;
         settle_q <= (on_q != on_prev_q) || (code_q != code_prev_q);
      end
   end

   always_comb begin
      state_d = ST_OFF;
      if (!activate_q) begin
         state_d = ST_DEACTIVATED;
      end else if (sleeping) begin
         state_d = ST_SLEEPING;
      end else if ((on_q != on_prev_q) || (code_q != code_prev_q) || settle_q) begin
         state_d = ST_CONVERTING;
      end else if (on_q) begin
         state_d = ST_ON;
      end else begin
         state_d = ST_OFF;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_DEACTIVATED;
      end else if (clk_en) begin
         case (state_q)
            ST_DEACTIVATED: state_q <= state_d;
            ST_SLEEPING: state_q <= state_d;
            ST_OFF: state_q <= state_d;
            ST_ON: state_q <= state_d;
            ST_CONVERTING: state_q <= state_d;
            default: state_q <= ST_DEACTIVATED;
         endcase
      end
   end

   assign power_state = state_q;

   // ==========================================================
   // Drive to the output stage
   assign aif.clock_gate = activate_q && !sleeping;
   assign aif.analog_on = on_q && activate_q && !sleeping;
   assign aif.pin_enable = config_q[CFG_PIN_BIT];
   assign aif.internal_enable = config_q[CFG_INTERNAL_BIT];
   assign aif.code = code_q;

   dac_output_stage stage (
      .clk(clk),
      .reset(reset),
      .soft_reset(soft_reset_q),
      .clk_en(clk_en),
      .port(aif.stage)
   );

   assign code_out = aif.code_out;
   assign pin_drive = aif.pin_drive;
   assign internal_drive = aif.internal_drive;
   assign pin_tristate = aif.pin_tristate;
   assign analog_on = aif.analog_on;
   assign clock_gate = aif.clock_gate;

   // ==========================================================
   // Checks
   a_on_needs_activate: assert property (@(posedge clk) disable iff (reset)
      on_q |-> $past(activate_q)) else $error("on bit set while deactivated");
   a_config_lock: assert property (@(posedge clk) disable iff (reset)
      (clk_en && on_q && !soft_reset_q) |=> $stable(config_q))
      else $error("configuration changed while on");
   a_soft_reset_clear: assert property (@(posedge clk) disable iff (reset)
      (clk_en && soft_reset_q) |=> (!on_q && config_q == CONFIG_RESET && code_q == CODE_RESET))
      else $error("soft reset left state");
   a_soft_spares_act: assert property (@(posedge clk) disable iff (reset)
      (clk_en && soft_reset_q && !(write_en && sel_activate)) |=> $stable(activate_q))
      else $error("soft reset touched activate");
   a_pin_follows: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !soft_reset_q) |=> (pin_drive == $past(aif.analog_on && config_q[CFG_PIN_BIT])))
      else $error("pin buffer wrong");
   a_sleep_tristate: assert property (@(posedge clk) disable iff (reset)
      (clk_en && sleeping) |=> pin_tristate) else $error("pin driven in sleep");
   a_sleep_ignored: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !soft_reset_q && !config_q[CFG_SLEEP_BIT] && on_q && activate_q
         && config_q[CFG_PIN_BIT]) |=> pin_drive)
      else $error("sleep not ignored");
   a_code_whole: assert property (@(posedge clk) disable iff (reset)
      (clk_en && write_en && sel_code && !soft_reset_q) |=> (code_q == $past(wdata[11:0])))
      else $error("code not taken whole");
   a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
      (clk_en && read_en && hit && offset >= OFF_RESERVED_FIRST) |=> (rdata == 32'h0000_0000))
      else $error("reserved read not zero");
   // ==========================================================
   // Register and power-state checks
   a_activate_write: assert property (@(posedge clk) disable iff (reset)
      (clk_en && write_en && sel_activate) |=> (activate_q == $past(wdata[ACTIVATE_BIT])))
      else $error("activate write lost");
   a_on_refused: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !activate_q) |=> !on_q) else $error("on bit accepted while deactivated");
   a_on_write_taken: assert property (@(posedge clk) disable iff (reset)
      (clk_en && write_en && sel_control && activate_q && !soft_reset_q
         && !wdata[CTRL_SOFT_RESET_BIT]) |=> (on_q == $past(wdata[CTRL_ON_BIT])))
      else $error("on bit write lost");
   a_config_taken: assert property (@(posedge clk) disable iff (reset)
      (clk_en && write_en && sel_config && !on_q && !soft_reset_q)
         |=> (config_q == $past(wdata[2:0])))
      else $error("configuration write lost");
   a_soft_self_clear: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !(write_en && sel_control && wdata[CTRL_SOFT_RESET_BIT])) |=> !soft_reset_q)
      else $error("soft reset stuck");
   a_deact_state: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !activate_q) |=> (power_state == ST_DEACTIVATED))
      else $error("not deactivated");
   a_sleep_state: assert property (@(posedge clk) disable iff (reset)
      (clk_en && activate_q && sleeping) |=> (power_state == ST_SLEEPING))
      else $error("not sleeping");
   a_converting_entry: assert property (@(posedge clk) disable iff (reset)
      (clk_en && activate_q && !sleeping && (on_q != on_prev_q))
         |=> (power_state == ST_CONVERTING))
      else $error("on change not converting");
   // ==========================================================
   // Stage checks, one cycle behind the core since the stage registers
   a_internal_follows: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !soft_reset_q)
         |=> (internal_drive == $past(aif.analog_on && config_q[CFG_INTERNAL_BIT])))
      else $error("internal buffer wrong");
   a_code_applied: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !soft_reset_q && aif.analog_on) |=> (code_out == $past(code_q)))
      else $error("code not applied while on");
   a_code_held_off: assert property (@(posedge clk) disable iff (reset)
      (clk_en && !soft_reset_q && !aif.analog_on) |=> $stable(code_out))
      else $error("code moved while off");
   c_turn_on: cover property (@(posedge clk) disable iff (reset) !on_q ##1 on_q);
   c_settled: cover property (@(posedge clk) disable iff (reset)
      state_q == ST_CONVERTING ##1 state_q == ST_ON);
   c_code_update: cover property (@(posedge clk) disable iff (reset)
      state_q == ST_ON ##1 state_q == ST_CONVERTING);
   c_sleep: cover property (@(posedge clk) disable iff (reset) state_q == ST_SLEEPING);
   c_soft_reset: cover property (@(posedge clk) disable iff (reset) soft_reset_q && on_q);

endmodule

// file: bench/dac_ladder_model.sv
/*
 Behavioural ladder and output buffers at the far side of the converter block.
 Assumes the drive and code signals are registered on the system clock.
*/
`timescale 1ns/1ps
module dac_ladder_model (
   // Clock
   input wire logic clk,
   // Drive from the block
   input wire logic [11:0] code_out,
   input wire logic pin_drive,
   input wire logic internal_drive,
   // Modelled levels
   output logic [11:0] pin_level = 12'h000,
   output logic [11:0] internal_level = 12'h000
);
   // ==========================================================
   // Buffers
   // Undriven paths wander, so a stale code never passes for a live one
   always_ff @(posedge clk) begin
      pin_level <= pin_drive ? code_out : ~pin_level;
      internal_level <= internal_drive ? code_out : ~internal_level;
   end
endmodule

// file: bench/dac_register_control_tb.sv
/*
 Self-checking bench for one converter instance at the default base.
 Assumes the 10 MHz clock and read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module dac_register_control_tb;
   import dac_ctrl_pkg::*;
   logic clk, reset, clk_en, write_en, read_en, sleep_enable;
   logic [15:0] addr;
   logic [31:0] wdata, rdata;
   logic [11:0] code_out, pin_level, internal_level;
   logic pin_drive, internal_drive, pin_tristate, analog_on, clock_gate;
   logic [4:0] power_state;
   int miscompares = 0;
   int samples_checked = 0;

   dac_register_control u_dac_register_control (.clk(clk), .reset(reset), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .write_en(write_en), .read_en(read_en), .rdata(rdata),
      .sleep_enable(sleep_enable), .code_out(code_out), .pin_drive(pin_drive),
      .internal_drive(internal_drive), .pin_tristate(pin_tristate), .analog_on(analog_on),
      .clock_gate(clock_gate), .power_state(power_state));
   dac_ladder_model u_dac_ladder_model (.clk(clk), .code_out(code_out),
      .pin_drive(pin_drive), .internal_drive(internal_drive),
      .pin_level(pin_level), .internal_level(internal_level));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // Bus and check tasks
   task automatic close_out();
      $display("checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] at(input logic [5:0] off);
      return INSTANCE0_BASE + {10'h000, off};
   endfunction

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      write_en <= 1'b1;
      @(posedge clk);
      write_en <= 1'b0;
   endtask

   task automatic rd_check(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      read_en <= 1'b1;
      @(posedge clk);
      read_en <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   // Bounded wait for a power state; running out counts as a mismatch
   task automatic wait_state(input power_state_type s);
      int n;
      #1;
      for (n = 0; n < 10 && power_state !== s; n++) begin
         @(posedge clk);
         #1;
      end
      check({27'h0, power_state}, {27'h0, s});
      if (power_state !== s) begin
         close_out();
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic reset_values();
      rd_check(at(OFF_ACTIVATE), 32'h0);
      rd_check(at(OFF_CONFIG), 32'h0);
      rd_check(at(OFF_CONTROL), 32'h0);
      rd_check(at(OFF_CODE), 32'h0);
      rd_check(at(OFF_RESERVED_FIRST), 32'h0);
      rd_check(INSTANCE1_BASE, 32'h0);
   endtask

   task automatic on_while_deactivated();
      wr(at(OFF_CONTROL), 32'h1);
      rd_check(at(OFF_CONTROL), 32'h0);
      check({30'h0, analog_on, clock_gate}, 32'h0);
      wr(at(OFF_CONFIG), 32'hffff_ffff);
      rd_check(at(OFF_CONFIG), 32'h7);
      wait_state(ST_DEACTIVATED);
   endtask

   task automatic buffer_table();
      int c;
      wr(at(OFF_ACTIVATE), 32'hffff_ffff);
      rd_check(at(OFF_ACTIVATE), 32'h1);
      for (c = 0; c < 4; c++) begin
         wr(at(OFF_CONFIG), c);
         wr(at(OFF_CODE), 32'h0000_0abc);
         wr(at(OFF_CONTROL), 32'h1);
         wait_state(ST_CONVERTING);
         wait_state(ST_ON);
         check({30'h0, pin_drive, internal_drive}, {30'h0, c[1], c[0]});
         check({31'h0, pin_tristate}, {31'h0, ~c[1]});
         check({20'h0, code_out}, 32'habc);
         wr(at(OFF_CONTROL), 32'h0);
         wait_state(ST_OFF);
         check({31'h0, analog_on}, 32'h0);
      end
   endtask

   task automatic update_while_on();
      wr(at(OFF_CONTROL), 32'h1);
      wr(at(OFF_CONFIG), 32'h0);
      rd_check(at(OFF_CONFIG), 32'h3);
      wr(at(OFF_CODE), 32'hffff_f5a5);
      rd_check(at(OFF_CODE), 32'h5a5);
      wait_state(ST_ON);
      repeat (2) @(posedge clk);
      #1;
      check({20'h0, code_out}, 32'h5a5);
      check({20'h0, pin_level}, 32'h5a5);
      check({20'h0, internal_level}, 32'h5a5);
      // A write while frozen must not land
      @(posedge clk);
      clk_en <= 1'b0;
      wr(at(OFF_CODE), 32'h0000_0123);
      clk_en <= 1'b1;
      rd_check(at(OFF_CODE), 32'h5a5);
   endtask

   task automatic sleep_cases();
      @(posedge clk);
      sleep_enable <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check({30'h0, pin_drive, analog_on}, 32'h3);
      wr(at(OFF_CONTROL), 32'h0);
      wr(at(OFF_CONFIG), 32'h7);
      wr(at(OFF_CONTROL), 32'h1);
      wait_state(ST_SLEEPING);
      check({29'h0, pin_tristate, analog_on, clock_gate}, 32'h4);
      @(posedge clk);
      sleep_enable <= 1'b0;
      wait_state(ST_ON);
      wr(at(OFF_CONTROL), 32'h0);
      @(posedge clk);
      sleep_enable <= 1'b1;
      wait_state(ST_SLEEPING);
      @(posedge clk);
      sleep_enable <= 1'b0;
      wait_state(ST_OFF);
   endtask

   task automatic soft_then_system_reset();
      wr(at(OFF_CONTROL), 32'h1);
      wr(at(OFF_CONTROL), 32'h2);
      repeat (SOFT_RESET_WAIT_CYCLES) @(posedge clk);
      rd_check(at(OFF_CONTROL), 32'h0);
      rd_check(at(OFF_CONFIG), 32'h0);
      rd_check(at(OFF_CODE), 32'h0);
      rd_check(at(OFF_ACTIVATE), 32'h1);
      wait_state(ST_OFF);
      wr(at(OFF_CONTROL), 32'h1);
      rd_check(at(OFF_CONTROL), 32'h1);
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd_check(at(OFF_ACTIVATE), 32'h0);
      wait_state(ST_DEACTIVATED);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      write_en = 1'b0;
      read_en = 1'b0;
      sleep_enable = 1'b0;
      addr = 16'h0000;
      wdata = 32'h0000_0000;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      reset_values();
      on_while_deactivated();
      buffer_table();
      update_while_on();
      sleep_cases();
      soft_then_system_reset();
      close_out();
   end
endmodule
